// *** rtl/serc_pkg.sv ***
// Shared constants for the sensor error routing and configuration block.
// Assumes a 16-bit register port with 8-bit addresses driven by a serial front end.
package serc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA0       = 8'h00;
    localparam logic [7:0] ADDR_STATUS      = 8'h18;
    localparam logic [7:0] ADDR_ERR_ROUTE   = 8'h19;
    localparam logic [7:0] ADDR_DEV_CFG     = 8'h1A;

    // ------------------------------------------------------------------
    // Error routing register fields
    // ------------------------------------------------------------------
    localparam int ER_UR_RES  = 15;
    localparam int ER_OR_RES  = 14;
    localparam int ER_WD_RES  = 13;
    localparam int ER_AH_RES  = 12;
    localparam int ER_AL_RES  = 11;
    localparam int ER_UR_IRQ  = 7;
    localparam int ER_OR_IRQ  = 6;
    localparam int ER_WD_IRQ  = 5;
    localparam int ER_AH_IRQ  = 4;
    localparam int ER_AL_IRQ  = 3;
    localparam int ER_ZC_IRQ  = 2;
    localparam int ER_DR_IRQ  = 0;
    localparam logic [15:0] ER_WMASK = 16'hF8FD;
    localparam logic [15:0] ER_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Device configuration register fields
    // ------------------------------------------------------------------
    localparam int DC_CHAN_HI   = 15;
    localparam int DC_CHAN_LO   = 14;
    localparam int DC_SLEEP     = 13;
    localparam int DC_OVERRIDE  = 12;
    localparam int DC_ACT_SEL   = 11;
    localparam int DC_AMP_DIS   = 10;
    localparam int DC_IRQ_DIS   = 7;
    localparam logic [15:0] DC_RESET = 16'h2801;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int ST_CHAN_LO = 14;
    localparam int ST_UR      = 13;
    localparam int ST_OR      = 12;
    localparam int ST_WD      = 11;
    localparam int ST_AH      = 10;
    localparam int ST_AL      = 9;
    localparam int ST_ZC      = 8;
    localparam int ST_DR      = 6;

    // Result register error flags, top four bits above a 12-bit result.
    localparam int RS_UR = 15;
    localparam int RS_OR = 14;
    localparam int RS_WD = 13;
    localparam int RS_AE = 12;
    localparam int RES_W = 12;
    localparam int NCH   = 4;

endpackage

// *** rtl/serc_chan_result.sv ***
// One channel result register with its four latched error flags.
// Assumes events and read strobes are single-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none

module serc_chan_result (
    input  wire logic                         clk,
    input  wire logic                         arst_n,
    input  wire logic                         conv_valid,
    input  wire logic [serc_pkg::RES_W-1:0]   conv_value,
    input  wire logic [3:0]                   flag_set,
    input  wire logic                         clear_rd,
    output var  logic [15:0]                  result_q
);

    typedef struct packed {
        logic [serc_pkg::RES_W-1:0] value;
        logic [3:0]                 flags;
    } serc_res_t;

    serc_res_t s_q;
    serc_res_t s_d;

    // A flag set in the same cycle as the read survives so the event is not lost.
    always_comb begin
        s_d = s_q;
        if (conv_valid) begin
            s_d.value = conv_value;
        end
        if (clear_rd) begin
            s_d.flags = 4'h0;
        end
        s_d.flags = s_d.flags | flag_set; // R20
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign result_q = {s_q.flags, s_q.value};

endmodule

`default_nettype wire

// *** rtl/serc_top.sv ***
// Error routing and device configuration registers of a four-channel converter.
// Assumes a serial front end delivers single-cycle register strobes on clk,
// and the conversion core delivers single-cycle event pulses per channel.
//
// Overview of operation
// R1 - Under-range result enable puts under-range errors into that channel's result flag.
// R2 - Over-range result enable puts over-range errors into that channel's result flag.
// R3 - Watchdog result enable puts watchdog errors into that channel's result flag.
// R4 - Amplitude-high result enable reports into the shared amplitude result flag.
// R5 - Amplitude-low result enable reports into the shared amplitude result flag.
// R6 - Under-range interrupt enable sets its status flag and asserts the pin.
// R7 - Over-range interrupt enable sets its status flag and asserts the pin.
// R8 - Watchdog interrupt enable sets its status flag and asserts the pin.
// R9 - Amplitude-high interrupt enable sets its status flag and asserts the pin.
// R10 - Amplitude-low interrupt enable sets its status flag and asserts the pin.
// R11 - Zero-count interrupt enable sets its status flag and asserts the pin.
// R12 - Result-ready interrupt enable sets its status flag and asserts the pin.
// R13 - Sources with interrupt enable clear touch neither pin nor status.
// R14 - Host writes zero to reserved routing bits 10 to 8 and 1.
// R15 - Two-bit channel field selects single conversion channel 0 to 3.
// R16 - Sleep bit enters low-power sleep when set; resets to one.
// R17 - Override bit uses programmed per-channel drive current; defaults off.
// R18 - Activation mode: zero full current, one programmed current; resets one.
// R19 - Amplitude correction disable stops correction and freezes initial drive current.
// R20 - Reported errors stay latched until status or that channel's result is read.
// R21 - Interrupt disable keeps the pin high regardless of status.
// R22 - Interrupt pin is active low and released when reads clear the condition.
// R23 - All routing enables reset to zero.
`timescale 1ns/1ps
`default_nettype none

module serc_top (
    input  wire logic                                clk,
    input  wire logic                                arst_n,
    // Register port from the serial front end.
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    input  wire logic [7:0]                          reg_addr,
    input  wire logic [15:0]                         reg_wdata,
    output logic      [15:0]                         reg_rdata,
    // Events from the conversion core.
    input  wire logic [1:0]                          evt_chan,
    input  wire logic                                evt_under_range,
    input  wire logic                                evt_over_range,
    input  wire logic                                evt_watchdog,
    input  wire logic                                evt_amp_high,
    input  wire logic                                evt_amp_low,
    input  wire logic                                evt_zero_count,
    input  wire logic                                evt_result_ready,
    input  wire logic [serc_pkg::RES_W-1:0]          evt_result,
    // Configuration outputs to the core.
    output logic      [1:0]                          single_channel_select,
    output logic                                     sleep_en,
    output logic                                     drive_current_override_en,
    output logic                                     activation_mode_sel,
    output logic                                     amp_correction_disable,
    output logic                                     irq_pin_n
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] err_route;
        logic [15:0] dev_cfg;
        logic [1:0]  st_chan;
        logic [6:0]  st_flags;
        logic [15:0] rdata;
        logic        irq_n;
    } serc_state_t;

    serc_state_t s_q;
    serc_state_t s_d;

    logic [15:0] res_word [serc_pkg::NCH];
    logic [3:0]  res_set  [serc_pkg::NCH];
    logic [serc_pkg::NCH-1:0] res_rd;

    // ------------------------------------------------------------------
    // Routing to the result registers
    // ------------------------------------------------------------------
    logic [3:0] res_flags;
    always_comb begin
        res_flags = 4'h0;
        res_flags[serc_pkg::RS_UR - serc_pkg::RES_W] =
            evt_under_range & s_q.err_route[serc_pkg::ER_UR_RES]; // R1
        res_flags[serc_pkg::RS_OR - serc_pkg::RES_W] =
            evt_over_range & s_q.err_route[serc_pkg::ER_OR_RES]; // R2
        res_flags[serc_pkg::RS_WD - serc_pkg::RES_W] =
            evt_watchdog & s_q.err_route[serc_pkg::ER_WD_RES]; // R3
        res_flags[serc_pkg::RS_AE - serc_pkg::RES_W] =
            (evt_amp_high & s_q.err_route[serc_pkg::ER_AH_RES]) // R4
            | (evt_amp_low & s_q.err_route[serc_pkg::ER_AL_RES]); // R5
    end

    genvar gi;
    generate
        for (gi = 0; gi < serc_pkg::NCH; gi++) begin : g_ch
            assign res_set[gi] = (evt_chan == 2'(gi)) ? res_flags : 4'h0;
            assign res_rd[gi]  = reg_rd && (reg_addr == serc_pkg::ADDR_DATA0 + 8'(2 * gi));
            serc_chan_result u_res (
                .clk        (clk),
                .arst_n     (arst_n),
                .conv_valid (evt_result_ready && (evt_chan == 2'(gi))),
                .conv_value (evt_result),
                .flag_set   (res_set[gi]),
                .clear_rd   (res_rd[gi]), // R20
                .result_q   (res_word[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status flags, ordered ur, or, wd, ah, al, zc, ready
    // ------------------------------------------------------------------
    logic [6:0] st_set;
    logic       st_rd;
    logic       err_rd;
    always_comb begin
        st_set = {evt_under_range  & s_q.err_route[serc_pkg::ER_UR_IRQ],  // R6
                  evt_over_range   & s_q.err_route[serc_pkg::ER_OR_IRQ],  // R7
                  evt_watchdog     & s_q.err_route[serc_pkg::ER_WD_IRQ],  // R8
                  evt_amp_high     & s_q.err_route[serc_pkg::ER_AH_IRQ],  // R9
                  evt_amp_low      & s_q.err_route[serc_pkg::ER_AL_IRQ],  // R10
                  evt_zero_count   & s_q.err_route[serc_pkg::ER_ZC_IRQ],  // R11
                  evt_result_ready & s_q.err_route[serc_pkg::ER_DR_IRQ]}; // R12 R13
        st_rd  = reg_rd && (reg_addr == serc_pkg::ADDR_STATUS);
        // Reading the result register of the channel that raised the error
        // also releases the latched status.
        err_rd = st_rd || (res_rd[s_q.st_chan] && (s_q.st_flags[6:1] != 6'h00));
    end

    // ------------------------------------------------------------------
    // Register file and pin
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (reg_wr && reg_addr == serc_pkg::ADDR_ERR_ROUTE) begin
            s_d.err_route = reg_wdata & serc_pkg::ER_WMASK; // R14
        end
        if (reg_wr && reg_addr == serc_pkg::ADDR_DEV_CFG) begin
            s_d.dev_cfg = reg_wdata;
        end
        if (err_rd) begin
            s_d.st_flags = 7'h00; // R20
        end
        // A new event in the clearing cycle wins over the clear.
        s_d.st_flags = s_d.st_flags | st_set;
        if (st_set != 7'h00) begin
            s_d.st_chan = evt_chan;
        end
        s_d.irq_n = s_q.dev_cfg[serc_pkg::DC_IRQ_DIS]
                    || (s_d.st_flags == 7'h00); // R21 R22
        s_d.rdata = s_q.rdata;
        if (reg_rd) begin
            unique case (reg_addr)
                serc_pkg::ADDR_STATUS: begin
                    s_d.rdata = '0;
                    s_d.rdata[serc_pkg::ST_CHAN_LO +: 2] = s_q.st_chan;
                    s_d.rdata[serc_pkg::ST_ZC +: 6]      = s_q.st_flags[6:1];
                    s_d.rdata[serc_pkg::ST_DR]           = s_q.st_flags[0];
                end
                serc_pkg::ADDR_ERR_ROUTE: s_d.rdata = s_q.err_route;
                serc_pkg::ADDR_DEV_CFG:   s_d.rdata = s_q.dev_cfg;
                default: begin
                    s_d.rdata = 16'h0000;
                    for (int i = 0; i < serc_pkg::NCH; i++) begin
                        if (res_rd[i]) begin
                            s_d.rdata = res_word[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.err_route <= serc_pkg::ER_RESET; // R23
            s_q.dev_cfg   <= serc_pkg::DC_RESET; // R16 R18
            s_q.st_chan   <= 2'b00;
            s_q.st_flags  <= 7'h00;
            s_q.rdata     <= 16'h0000;
            s_q.irq_n     <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign reg_rdata                 = s_q.rdata;
    assign irq_pin_n                 = s_q.irq_n;
    assign single_channel_select     = s_q.dev_cfg[serc_pkg::DC_CHAN_LO +: 2]; // R15
    assign sleep_en                  = s_q.dev_cfg[serc_pkg::DC_SLEEP]; // R16
    assign drive_current_override_en = s_q.dev_cfg[serc_pkg::DC_OVERRIDE]; // R17
    assign activation_mode_sel       = s_q.dev_cfg[serc_pkg::DC_ACT_SEL]; // R18
    assign amp_correction_disable    = s_q.dev_cfg[serc_pkg::DC_AMP_DIS]; // R19

endmodule

`default_nettype wire

// *** bench/serc_chk.sv ***
// Checker on the routing and configuration block's top-level ports.
// Assumes single-cycle register strobes and event pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module serc_chk (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        evt_under_range,
    input wire logic        evt_over_range,
    input wire logic        evt_watchdog,
    input wire logic        evt_amp_high,
    input wire logic        evt_amp_low,
    input wire logic        evt_zero_count,
    input wire logic        evt_result_ready,
    input wire logic [1:0]  single_channel_select,
    input wire logic        sleep_en,
    input wire logic        drive_current_override_en,
    input wire logic        activation_mode_sel,
    input wire logic        amp_correction_disable,
    input wire logic        irq_pin_n
);
    logic [15:0] rt_q;
    logic [15:0] cf_q;
    logic [6:0]  ev;
    logic [6:0]  en;
    logic        cf_wr;
    assign ev = {evt_under_range, evt_over_range, evt_watchdog, evt_amp_high,
                 evt_amp_low, evt_zero_count, evt_result_ready};
    assign en = {rt_q[7:2], rt_q[0]};
    assign cf_wr = reg_wr && reg_addr == serc_pkg::ADDR_DEV_CFG;
    // Mirrors of host writes, so pin behaviour can be judged from the ports alone.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rt_q <= serc_pkg::ER_RESET;
            cf_q <= serc_pkg::DC_RESET;
        end else if (reg_wr) begin
            if (reg_addr == serc_pkg::ADDR_ERR_ROUTE)
                rt_q <= reg_wdata & serc_pkg::ER_WMASK;
            if (cf_wr)
                cf_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence irq_evt_s;
        |(ev & en) && !cf_q[7];
    endsequence
    sequence stat_rd_s;
        reg_rd && reg_addr == serc_pkg::ADDR_STATUS && !(|(ev & en));
    endsequence
    irq_raise_a: assert property (irq_evt_s |=> !irq_pin_n)
        else $error("pin not asserted after enabled event");
    irq_quiet_a: assert property (irq_pin_n && !(|(ev & en)) && !cf_wr && !$past(cf_wr)
        |=> irq_pin_n) else $error("pin asserted without enabled event");
    // The pin follows a config write one cycle late, so the write before counts too.
    irq_latch_a: assert property (!irq_pin_n && !reg_rd && !cf_wr && !$past(cf_wr)
        |=> !irq_pin_n)
        else $error("pin released without a read");
    irq_clear_a: assert property (stat_rd_s |=> irq_pin_n)
        else $error("pin not released by status read");
    irq_dis_a: assert property (cf_q[7] && $past(cf_q[7]) |-> irq_pin_n)
        else $error("pin low while disabled");
    route_rb_a: assert property (reg_rd && reg_addr == serc_pkg::ADDR_ERR_ROUTE
        |=> reg_rdata == $past(rt_q)) else $error("routing readback wrong");
    cfg_out_a: assert property (!cf_wr && !$past(cf_wr) |->
        {single_channel_select, sleep_en, drive_current_override_en, activation_mode_sel,
         amp_correction_disable} == cf_q[15:10]) else $error("config outputs wrong");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    unmapped_a: assert property (reg_rd && reg_addr > serc_pkg::ADDR_DEV_CFG
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule
bind serc_top serc_chk u_chk (
    .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .evt_under_range(evt_under_range),
    .evt_over_range(evt_over_range), .evt_watchdog(evt_watchdog),
    .evt_amp_high(evt_amp_high), .evt_amp_low(evt_amp_low),
    .evt_zero_count(evt_zero_count), .evt_result_ready(evt_result_ready),
    .single_channel_select(single_channel_select), .sleep_en(sleep_en),
    .drive_current_override_en(drive_current_override_en),
    .activation_mode_sel(activation_mode_sel),
    .amp_correction_disable(amp_correction_disable), .irq_pin_n(irq_pin_n));
`default_nettype wire

// *** bench/serc_host.sv ***
// Host controller model issuing register strobes at the falling clock edge.
// Assumes the block answers a read with registered data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module serc_host (
    input  wire logic        clk,
    input  wire logic [15:0] reg_rdata,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    output var  logic [7:0]  reg_addr,
    output var  logic [15:0] reg_wdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'hFF;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = (a == serc_pkg::ADDR_ERR_ROUTE) ? (d & serc_pkg::ER_WMASK) : d;
        @(negedge clk);
        reg_wr = 1'b0;
        // Stale data is inverted so nothing relies on a lingering value.
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd   = 1'b0;
        d        = reg_rdata;
        reg_addr = ~reg_addr;
    endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench: host model accesses plus event pulses from the core side.
// Assumes events are single-cycle pulses driven at the falling edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
    logic                      clk;
    logic                      arst_n;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [7:0]                reg_addr;
    logic [15:0]               reg_wdata;
    logic [15:0]               reg_rdata;
    logic [6:0]                ev;
    logic [1:0]                evt_chan;
    logic [serc_pkg::RES_W-1:0] evt_result;
    logic [1:0]                ch_sel;
    logic                      slp, ovr, act, amp, irq_n;
    logic [15:0]               rd_v;
    logic [5:0]                cv;
    int                        err_count = 0;
    int                        comparisons = 0;
    int                        irq_bit [7] = '{7, 6, 5, 4, 3, 2, 0};
    int                        st_bit  [7] = '{13, 12, 11, 10, 9, 8, 6};
    int                        rs_bit  [5] = '{15, 14, 13, 12, 12};
    serc_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    serc_top u_dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .evt_chan(evt_chan), .evt_under_range(ev[6]), .evt_over_range(ev[5]),
        .evt_watchdog(ev[4]), .evt_amp_high(ev[3]), .evt_amp_low(ev[2]),
        .evt_zero_count(ev[1]), .evt_result_ready(ev[0]), .evt_result(evt_result),
        .single_channel_select(ch_sel), .sleep_en(slp), .drive_current_override_en(ovr),
        .activation_mode_sel(act), .amp_correction_disable(amp), .irq_pin_n(irq_n));
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic pulse(input logic [6:0] e, input logic [1:0] c);
        @(negedge clk);
        ev         = e;
        evt_chan   = c;
        evt_result = 12'hA5C;
        @(negedge clk);
        ev = 7'h00;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] x);
        u_host.rd(a, rd_v);
        `CHK(rd_v, x)
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 3000);
        err_count++;
        end_sim();
    end
    initial begin
        arst_n = 1'b0;
        ev = 7'h00;
        evt_chan = 2'b00;
        evt_result = 12'h000;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        rchk(serc_pkg::ADDR_ERR_ROUTE, 16'h0000);
        `CHK({slp, act, ch_sel, ovr, amp}, 6'b110000)
        rchk(8'h30, 16'h0000);
        u_host.wr(serc_pkg::ADDR_ERR_ROUTE, 16'hFFFF);
        rchk(serc_pkg::ADDR_ERR_ROUTE, 16'hF8FD);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            cv = {i[1:0], i[0], i[1], ~i[0], i[1]};
            u_host.wr(serc_pkg::ADDR_DEV_CFG, {cv, 10'h001});
            `CHK({ch_sel, slp, ovr, act, amp}, cv)
        end
        u_host.wr(serc_pkg::ADDR_DEV_CFG, 16'h0001);
        $display("test config done");
        for (int i = 0; i < 7; i++) begin
            u_host.wr(serc_pkg::ADDR_ERR_ROUTE, 16'h0001 << irq_bit[i]);
            pulse(7'h40 >> i, 2'b00);
            `CHK(irq_n, 1'b0)
            rchk(serc_pkg::ADDR_STATUS, 16'h0001 << st_bit[i]);
            `CHK(irq_n, 1'b1)
            u_host.wr(serc_pkg::ADDR_ERR_ROUTE, 16'h0000);
            pulse(7'h40 >> i, 2'b00);
            `CHK(irq_n, 1'b1)
            rchk(serc_pkg::ADDR_STATUS, 16'h0000);
        end
        $display("test irq routing done");
        for (int i = 0; i < 5; i++) begin
            u_host.wr(serc_pkg::ADDR_ERR_ROUTE, 16'h8000 >> i);
            pulse((7'h40 >> i) | 7'h01, 2'b10);
            rchk(8'h04, (16'h0001 << rs_bit[i]) | 16'h0A5C);
            u_host.wr(serc_pkg::ADDR_ERR_ROUTE, 16'h0000);
            pulse((7'h40 >> i) | 7'h01, 2'b10);
            rchk(8'h04, 16'h0A5C);
        end
        $display("test result flags done");
        u_host.wr(serc_pkg::ADDR_ERR_ROUTE, 16'h0020);
        u_host.wr(serc_pkg::ADDR_DEV_CFG, 16'h0081);
        pulse(7'h10, 2'b00);
        `CHK(irq_n, 1'b1)
        u_host.wr(serc_pkg::ADDR_DEV_CFG, 16'h0001);
        repeat (2) @(negedge clk);
        `CHK(irq_n, 1'b0)
        rchk(serc_pkg::ADDR_STATUS, 16'h0800);
        $display("test irq disable done");
        pulse(7'h10, 2'b11);
        `CHK(irq_n, 1'b0)
        rchk(serc_pkg::ADDR_STATUS, 16'hC800);
        pulse(7'h10, 2'b11);
        rchk(8'h02, 16'h0000);
        `CHK(irq_n, 1'b0)
        rchk(8'h06, 16'h0000);
        `CHK(irq_n, 1'b1)
        rchk(serc_pkg::ADDR_STATUS, 16'hC000);
        $display("test result read clear done");
        end_sim();
    end
endmodule
`default_nettype wire
